// *** src/usr_core.sv ***
// Summary of operation
// - Data writes fill the transmit buffer; data reads return oldest receive entry.
// - Short characters ignore upper transmit bits and receive them as zeros.
// - Buffer-empty flag is one after reset; writes while zero are dropped.
// - Enabled transmitter loads buffered data into an empty shifter, then shifts out.
// - Receive buffer is a two-entry FIFO advanced by each data read while it holds data.
// - Receive-complete flag is high exactly while the receive FIFO holds data.
// - Transmit-complete sets after last frame with empty buffer; ack or one clears.
// - Frame error reports a zero first stop bit of the head character.
// - Overrun sets on a start bit with full FIFO and waiting character.
// - Parity error reports a checked parity mismatch of the head character.
// - Double speed uses eight samples per bit instead of sixteen, async only.
// - Address filtering drops frames whose frame-type bit is zero.
// - Each interrupt request needs its enable, global enable and its flag.
// - Receiver enable owns input pin; disable flushes FIFO and error flags.
// - Transmitter disable waits for empty shifter and buffer before releasing pin.
// - Mode field selects synchronous with code one; every other code runs asynchronous.
// - Parity field selects none, even or odd; transmit appends, receive checks.
// - Stop select gives one or two transmit stop bits; receiver ignores it.
// - Size bits select five to eight or nine bit characters both directions.
// - Sync polarity picks link-clock edges for transmit change and receive sample.
// - Twelve-bit divisor; low byte write reloads the prescaler at once.
// - Frame-type bit one marks address frames, zero marks data frames.
`timescale 1ns/100ps
module usr_core
	import usr_pkg::*;
(
	input  wire logic       i_mclk,    // System clock
	input  wire logic       i_rst_b,   // Async reset, low
	input  wire logic       i_ce,      // Clock enable
	input  wire logic [2:0] i_addr,    // Register offset
	input  wire logic [7:0] i_wdata,   // Write data
	input  wire logic       i_wr,      // Write strobe
	input  wire logic       i_rd,      // Read strobe
	output logic      [7:0] o_rdata,   // Read data, next cycle
	input  wire logic       i_gie,     // Global interrupt enable
	input  wire logic       i_txc_ack, // Tx-done interrupt served
	input  wire logic       i_rxd,     // serial_in_pin
	input  wire logic       i_xck,     // sync_link_clock input
	output logic            o_txd,     // serial_out_pin
	output logic            o_txd_en,  // Transmitter owns pin
	output logic            o_rxd_en,  // Receiver owns pin
	output logic            o_irq_rx,  // Rx-done request
	output logic            o_irq_tx,  // Tx-done request
	output logic            o_irq_ue   // Tx-empty request
);
	logic [7:0]  ctb_r, ctb_nxt, fmt_r, fmt_nxt, rdata_r, rdata_nxt;
	logic [11:0] div_r, div_nxt;
	logic        u2x_r, u2x_nxt, mpcm_r, mpcm_nxt, txc_r, txc_nxt;
	logic        tbv_r, tbv_nxt, own_r, own_nxt, txd_r, txd_nxt;
	logic        tpar_r, tpar_nxt, tsec_r, tsec_nxt, xck_q;
	logic [8:0]  tb_r, tb_nxt, tsh_r, tsh_nxt;
	logic [3:0]  tsub_r, tsub_nxt, tbit_r, tbit_nxt;
	usr_st_t     tst_r, tst_nxt, rst_r, rst_nxt;
	usr_rx_ent_t fifo_r [2];
	usr_rx_ent_t fifo_nxt [2];
	usr_rx_ent_t pend_r, pend_nxt, ent;
	logic        pv_r, pv_nxt, rptr_r, rptr_nxt, dor_r, dor_nxt;
	logic        rpe_r, rpe_nxt, pop, done, accept, flush;
	logic [1:0]  cnt_r, cnt_nxt;
	logic [8:0]  rsh_r, rsh_nxt, mask;
	logic [3:0]  rsub_r, rsub_nxt, rbit_r, rbit_nxt, nlast, sublast;
	logic        tick, sync, par_en, odd, tedge, redge, tbend, rsamp, rxc, udre;
	logic [2:0]  size;
	logic        div_load;

	assign size = {ctb_r[CB_SZH], fmt_r[FC_SZL +: 2]};
	assign sync = (fmt_r[FC_MODE +: 2] == MODE_SYN);
	assign par_en = fmt_r[FC_PAR + 1];
	assign odd = fmt_r[FC_PAR];
	assign sublast = (u2x_r && !sync) ? SUB_DBL : SUB_NORM;
	assign rxc = (cnt_r != 2'h0);
	assign udre = !tbv_r;
	assign div_load = i_wr && (i_addr == ADR_DIVL);
	assign pop = i_rd && (i_addr == ADR_DATA) && rxc;
	assign flush = !ctb_r[CB_RXEN];

	// Character length and data mask
	always_comb begin
		if (size == SZ_NINE) begin
			nlast = 4'h8;
		end else if (size[2]) begin
			nlast = 4'h7;
		end else begin
			nlast = {2'b01, size[1:0]} + 4'h0;
		end
		mask = 9'h1ff >> (4'h8 - nlast);
	end

	// Link-clock edges; pins are synchronous to i_mclk
	assign tedge = fmt_r[FC_POL] ? (xck_q && !i_xck) : (!xck_q && i_xck);
	assign redge = fmt_r[FC_POL] ? (!xck_q && i_xck) : (xck_q && !i_xck);
	assign tbend = sync ? tedge : (tick && tsub_r == sublast);
	assign rsamp = sync ? redge : (tick && rsub_r == sublast);

	usr_baud_gen u_baud (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_div   (div_nxt),
		.i_load  (div_load),
		.o_tick  (tick)
	);

	// Registers, bus and transmitter
	always_comb begin
		ctb_nxt = ctb_r;
		fmt_nxt = fmt_r;
		div_nxt = div_r;
		u2x_nxt = u2x_r;
		mpcm_nxt = mpcm_r;
		txc_nxt = txc_r;
		tbv_nxt = tbv_r;
		tb_nxt = tb_r;
		own_nxt = own_r;
		txd_nxt = txd_r;
		tpar_nxt = tpar_r;
		tsec_nxt = tsec_r;
		tsh_nxt = tsh_r;
		tsub_nxt = tsub_r;
		tbit_nxt = tbit_r;
		tst_nxt = tst_r;
		rdata_nxt = 8'h00;
		if (i_rd) begin
			if (i_addr == ADR_DATA) begin
				rdata_nxt = fifo_r[rptr_r].data[7:0];
			end else if (i_addr == ADR_STA) begin
				rdata_nxt = {rxc, txc_r, udre, fifo_r[rptr_r].fe && rxc,
					dor_r, fifo_r[rptr_r].pe && rxc, u2x_r, mpcm_r};
			end else if (i_addr == ADR_CTB) begin
				rdata_nxt = ctb_r;
				rdata_nxt[CB_RX9] = fifo_r[rptr_r].data[8];
			end else if (i_addr == ADR_FMT) begin
				rdata_nxt = fmt_r;
			end else if (i_addr == ADR_DIVL) begin
				rdata_nxt = div_r[7:0];
			end else if (i_addr == ADR_DIVH) begin
				rdata_nxt = {4'h0, div_r[11:8]};
			end
		end
		if (i_txc_ack) begin
			txc_nxt = 1'b0;
		end
		if (i_wr) begin
			if (i_addr == ADR_DATA) begin
				if (udre) begin
					tb_nxt = {ctb_r[CB_TX9], i_wdata};
					tbv_nxt = 1'b1;
				end
			end else if (i_addr == ADR_STA) begin
				u2x_nxt = i_wdata[SA_U2X];
				mpcm_nxt = i_wdata[SA_MPCM];
				if (i_wdata[SA_TXC]) begin
					txc_nxt = 1'b0;
				end
			end else if (i_addr == ADR_CTB) begin
				ctb_nxt = i_wdata;
				ctb_nxt[CB_RX9] = 1'b0;
			end else if (i_addr == ADR_FMT) begin
				fmt_nxt = i_wdata;
			end else if (i_addr == ADR_DIVL) begin
				div_nxt[7:0] = i_wdata;
			end else if (i_addr == ADR_DIVH) begin
				div_nxt[11:8] = i_wdata[3:0];
			end
		end
		if (!sync && tst_r != ST_IDLE && tick) begin
			tsub_nxt = (tsub_r == sublast) ? 4'h0 : tsub_r + 4'h1;
		end
		case (tst_r)
			ST_IDLE: begin
				txd_nxt = 1'b1;
				if (own_r && tbv_r) begin
					tsh_nxt = tb_r & mask;
					tpar_nxt = ^(tb_r & mask) ^ odd;
					tbv_nxt = 1'b0;
					tsub_nxt = 4'h0;
					txd_nxt = 1'b0;
					tst_nxt = ST_START;
				end else if (!ctb_r[CB_TXEN]) begin
					own_nxt = 1'b0;
				end
			end
			ST_START: begin
				if (tbend) begin
					txd_nxt = tsh_r[0];
					tbit_nxt = 4'h0;
					tst_nxt = ST_DATA;
				end
			end
			ST_DATA: begin
				if (tbend) begin
					if (tbit_r == nlast) begin
						txd_nxt = par_en ? tpar_r : 1'b1;
						tsec_nxt = 1'b0;
						tst_nxt = par_en ? ST_PAR : ST_STOP;
					end else begin
						tsh_nxt = tsh_r >> 1;
						txd_nxt = tsh_r[1];
						tbit_nxt = tbit_r + 4'h1;
					end
				end
			end
			ST_PAR: begin
				if (tbend) begin
					txd_nxt = 1'b1;
					tst_nxt = ST_STOP;
				end
			end
			ST_STOP: begin
				if (tbend) begin
					if (fmt_r[FC_STOP] && !tsec_r) begin
						tsec_nxt = 1'b1;
					end else begin
						tst_nxt = ST_IDLE;
						if (!tbv_nxt) begin
							txc_nxt = 1'b1;
						end
					end
				end
			end
			default: begin
				tst_nxt = ST_IDLE;
			end
		endcase
		if (ctb_nxt[CB_TXEN]) begin
			own_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctb_r <= CTB_RST;
			fmt_r <= FMT_RST;
			div_r <= 12'h000;
			u2x_r <= 1'b0;
			mpcm_r <= 1'b0;
			txc_r <= 1'b0;
			tbv_r <= 1'b0;
			tb_r <= 9'h000;
			own_r <= 1'b0;
			txd_r <= 1'b1;
			tpar_r <= 1'b0;
			tsec_r <= 1'b0;
			tsh_r <= 9'h000;
			tsub_r <= 4'h0;
			tbit_r <= 4'h0;
			tst_r <= ST_IDLE;
			rdata_r <= 8'h00;
			xck_q <= 1'b0;
		end else if (i_ce) begin
			ctb_r <= ctb_nxt;
			fmt_r <= fmt_nxt;
			div_r <= div_nxt;
			u2x_r <= u2x_nxt;
			mpcm_r <= mpcm_nxt;
			txc_r <= txc_nxt;
			tbv_r <= tbv_nxt;
			tb_r <= tb_nxt;
			own_r <= own_nxt;
			txd_r <= txd_nxt;
			tpar_r <= tpar_nxt;
			tsec_r <= tsec_nxt;
			tsh_r <= tsh_nxt;
			tsub_r <= tsub_nxt;
			tbit_r <= tbit_nxt;
			tst_r <= tst_nxt;
			rdata_r <= rdata_nxt;
			xck_q <= i_xck;
		end
	end

	// Receiver and two-entry FIFO
	always_comb begin
		fifo_nxt = fifo_r;
		pend_nxt = pend_r;
		pv_nxt = pv_r;
		rptr_nxt = rptr_r ^ pop;
		cnt_nxt = cnt_r - {1'b0, pop};
		dor_nxt = dor_r && !pop;
		rpe_nxt = rpe_r;
		rsh_nxt = rsh_r;
		rsub_nxt = rsub_r;
		rbit_nxt = rbit_r;
		rst_nxt = rst_r;
		done = 1'b0;
		ent = '{data: rsh_r, fe: !i_rxd, pe: rpe_r};
		accept = !mpcm_r || ((nlast == 4'h8) ? rsh_r[8] : i_rxd);
		if (!sync && rst_r != ST_IDLE && tick) begin
			rsub_nxt = (rsub_r == sublast) ? 4'h0 : rsub_r + 4'h1;
		end
		case (rst_r)
			ST_IDLE: begin
				if ((sync && redge) || (!sync && tick)) begin
					if (!i_rxd) begin
						rsh_nxt = 9'h000;
						rsub_nxt = 4'h0;
						rbit_nxt = 4'h0;
						rst_nxt = sync ? ST_DATA : ST_START;
						if (cnt_r == 2'h2 && pv_r) begin
							dor_nxt = 1'b1;
						end
					end
				end
			end
			ST_START: begin
				if (tick && rsub_r == (sublast >> 1)) begin
					rsub_nxt = 4'h0;
					rst_nxt = i_rxd ? ST_IDLE : ST_DATA;
				end
			end
			ST_DATA: begin
				if (rsamp) begin
					rsh_nxt[rbit_r] = i_rxd;
					rbit_nxt = rbit_r + 4'h1;
					if (rbit_r == nlast) begin
						rst_nxt = par_en ? ST_PAR : ST_STOP;
						rpe_nxt = 1'b0;
					end
				end
			end
			ST_PAR: begin
				if (rsamp) begin
					rpe_nxt = i_rxd != (^rsh_r ^ odd);
					rst_nxt = ST_STOP;
				end
			end
			ST_STOP: begin
				if (rsamp) begin
					done = accept;
					rst_nxt = ST_IDLE;
				end
			end
			default: begin
				rst_nxt = ST_IDLE;
			end
		endcase
		if (pv_r && cnt_nxt != 2'h2) begin
			fifo_nxt[rptr_nxt ^ cnt_nxt[0]] = pend_r;
			cnt_nxt = cnt_nxt + 2'h1;
			pv_nxt = 1'b0;
		end
		if (done) begin
			if (cnt_nxt != 2'h2) begin
				fifo_nxt[rptr_nxt ^ cnt_nxt[0]] = ent;
				cnt_nxt = cnt_nxt + 2'h1;
			end else if (!pv_nxt) begin
				pend_nxt = ent;
				pv_nxt = 1'b1;
			end
		end
		if (flush) begin
			cnt_nxt = 2'h0;
			pv_nxt = 1'b0;
			dor_nxt = 1'b0;
			rst_nxt = ST_IDLE;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fifo_r <= '{default: '0};
			pend_r <= '0;
			pv_r <= 1'b0;
			rptr_r <= 1'b0;
			cnt_r <= 2'h0;
			dor_r <= 1'b0;
			rpe_r <= 1'b0;
			rsh_r <= 9'h000;
			rsub_r <= 4'h0;
			rbit_r <= 4'h0;
			rst_r <= ST_IDLE;
		end else if (i_ce) begin
			fifo_r <= fifo_nxt;
			pend_r <= pend_nxt;
			pv_r <= pv_nxt;
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_nxt;
			dor_r <= dor_nxt;
			rpe_r <= rpe_nxt;
			rsh_r <= rsh_nxt;
			rsub_r <= rsub_nxt;
			rbit_r <= rbit_nxt;
			rst_r <= rst_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_txd = own_r ? txd_r : 1'b1;
	assign o_txd_en = own_r;
	assign o_rxd_en = ctb_r[CB_RXEN];
	assign o_irq_rx = i_gie && ctb_r[CB_RXIE] && rxc;
	assign o_irq_tx = i_gie && ctb_r[CB_TXIE] && txc_r;
	assign o_irq_ue = i_gie && ctb_r[CB_UEIE] && udre;

	drop_full_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && i_wr && i_addr == ADR_DATA && tbv_r) |=> (tb_r == $past(tb_r)))
		else $error("Write into full buffer not dropped");
	load_shift_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && tst_r == ST_IDLE && own_r && tbv_r) |=> (tst_r == ST_START && !o_txd))
		else $error("Buffered data not loaded");
	rx_pop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && pop && cnt_r == 2'h1 && !done && !pv_r) |=> !rxc)
		else $error("Data read did not empty FIFO");
	tx_done_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && tst_r == ST_STOP && tst_nxt == ST_IDLE && !tbv_nxt) |=> txc_r)
		else $error("Transmit complete not set");
	flush_rx_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && flush) |=> (!rxc && !dor_r))
		else $error("Receiver disable did not flush");
	pin_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && own_r && (tst_r != ST_IDLE || tbv_r)) |=> own_r)
		else $error("Pin released with data pending");
	txc_ack_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && i_txc_ack && !(tst_r == ST_STOP && tst_nxt == ST_IDLE)) |=> !txc_r)
		else $error("Tx-done flag not cleared by ack");
	overrun_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && !flush && rst_r == ST_IDLE && rst_nxt != ST_IDLE && cnt_r == 2'h2
		&& pv_r) |=> dor_r)
		else $error("Overrun not flagged");
endmodule // usr_core

// *** src/usr_pkg.sv ***
package usr_pkg;
	// Register offsets
	localparam logic [2:0] ADR_DATA = 3'h0;
	localparam logic [2:0] ADR_STA  = 3'h1;
	localparam logic [2:0] ADR_CTB  = 3'h2;
	localparam logic [2:0] ADR_FMT  = 3'h3;
	localparam logic [2:0] ADR_DIVL = 3'h4;
	localparam logic [2:0] ADR_DIVH = 3'h5;
	// status_and_speed_ctrl fields
	localparam int SA_RXC  = 7;
	localparam int SA_TXC  = 6;
	localparam int SA_UDRE = 5;
	localparam int SA_FE   = 4;
	localparam int SA_DOR  = 3;
	localparam int SA_PE   = 2;
	localparam int SA_U2X  = 1;
	localparam int SA_MPCM = 0;
	// irq_and_enable_ctrl fields
	localparam int CB_RXIE = 7;
	localparam int CB_TXIE = 6;
	localparam int CB_UEIE = 5;
	localparam int CB_RXEN = 4;
	localparam int CB_TXEN = 3;
	localparam int CB_SZH  = 2;
	localparam int CB_RX9  = 1;
	localparam int CB_TX9  = 0;
	// frame_format_ctrl fields
	localparam int FC_MODE = 6;
	localparam int FC_PAR  = 4;
	localparam int FC_STOP = 3;
	localparam int FC_SZL  = 1;
	localparam int FC_POL  = 0;
	// Reset values, mode and size codes
	localparam logic [7:0] FMT_RST  = 8'h06;
	localparam logic [7:0] CTB_RST  = 8'h00;
	localparam logic [1:0] MODE_SYN = 2'h1;
	localparam logic [2:0] SZ_NINE  = 3'h7;
	// Samples per bit minus one, normal and double speed
	localparam logic [3:0] SUB_NORM = 4'hf;
	localparam logic [3:0] SUB_DBL  = 4'h7;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_DATA  = 3'b011,
		ST_PAR   = 3'b010,
		ST_STOP  = 3'b110
	} usr_st_t;

	typedef struct packed {
		logic [8:0] data;
		logic       fe;
		logic       pe;
	} usr_rx_ent_t;
endpackage

// *** src/usr_baud_gen.sv ***
`timescale 1ns/100ps
module usr_baud_gen
	import usr_pkg::*;
(
	input  wire logic        i_mclk,  // System clock
	input  wire logic        i_rst_b, // Async reset, low
	input  wire logic        i_ce,    // Clock enable
	input  wire logic [11:0] i_div,   // Divisor value
	input  wire logic        i_load,  // Reload request
	output logic             o_tick   // One sample tick
);
	logic [11:0] cnt_r;
	logic [11:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		o_tick = 1'b0;
		if (i_load) begin
			cnt_nxt = i_div;
		end else if (cnt_r == 12'h000) begin
			cnt_nxt = i_div;
			o_tick = 1'b1;
		end else begin
			cnt_nxt = cnt_r - 12'h001;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= 12'h000;
		end else if (i_ce) begin
			cnt_r <= cnt_nxt;
		end
	end

	reload_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ce && i_load) |=> (cnt_r == $past(i_div)))
		else $error("Divisor reload missed");
endmodule // usr_baud_gen

// *** tb/usr_peer.sv ***
`timescale 1ns/100ps
module usr_peer (
	input  wire logic i_mclk,   // System clock
	input  wire logic i_txd,    // Device serial output
	input  wire logic i_txd_en, // Device owns its output
	output logic      o_rxd,    // Into device serial input
	output logic      o_xck     // Link clock into device
);
	int          bit_clks = 16;
	int          rx_len   = 10;
	logic [15:0] got_q[$];
	time         t_q[$];
	logic [15:0] f;

	initial begin
		o_rxd = 1'b1;
		o_xck = 1'b0;
	end

	// Start, data lsb first, parity, stops; last bit is always a one
	task automatic send(input logic [15:0] fr, input int len);
		for (int i = 0; i < len; i++) begin
			o_rxd <= fr[i];
			repeat (bit_clks) @(posedge i_mclk);
		end
	endtask

	// Synchronous frame; leading clock edge moves both lines, trailing edge samples
	task automatic sync_xfer(input logic [15:0] fr, input int n, input logic pol,
		output logic [15:0] got);
		got   = '1;
		o_xck <= pol;
		repeat (4) @(posedge i_mclk);
		for (int i = 0; i < n; i++) begin
			got[i] = i_txd;
			o_xck  <= !pol;
			o_rxd  <= fr[i];
			repeat (4) @(posedge i_mclk);
			o_xck <= pol;
			repeat (4) @(posedge i_mclk);
		end
	endtask

	// Capture frames from the device, sampled at bit centres
	initial begin
		forever begin
			@(negedge i_txd);
			if (i_txd_en) begin
				t_q.push_back($time);
				f = '1;
				repeat (bit_clks / 2) @(posedge i_mclk);
				for (int i = 0; i < rx_len; i++) begin
					if (i > 0)
						repeat (bit_clks) @(posedge i_mclk);
					f[i] = i_txd;
				end
				got_q.push_back(f);
			end
		end
	end
endmodule // usr_peer

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	import usr_pkg::*;

	typedef struct packed {
		logic [7:0] fmt; // Frame format value
		logic       szh; // char_size_high
		logic [8:0] d;   // Character sent both ways
		logic [3:0] nb;  // Expected data bits
		logic [7:0] rx_holding_buffer; // Expected low byte received
	} usr_row_t;

	logic        i_mclk, i_rst_b, i_wr, i_rd, i_gie, i_txc_ack, rxd, xck, ce;
	logic [2:0]  i_addr;
	logic [7:0]  i_wdata, o_rdata, v;
	logic        o_txd, o_txd_en, o_rxd_en, o_irq_rx, o_irq_tx, o_irq_ue;
	logic [15:0] ef;
	int          len;
	int          n_mismatch = 0;
	int          compares   = 0;
	time         dt;
	wire [5:0]   pins = {o_txd, o_txd_en, o_rxd_en, o_irq_rx, o_irq_tx, o_irq_ue};
	usr_row_t    rows[6] = '{
		'{8'h00, 1'b0, 9'h1ff, 4'h5, 8'h1f},
		'{8'h2a, 1'b0, 9'h0ad, 4'h6, 8'h2d},
		'{8'h34, 1'b0, 9'h0c3, 4'h7, 8'h43},
		'{8'h16, 1'b0, 9'h0a5, 4'h8, 8'ha5},
		'{8'h26, 1'b1, 9'h15a, 4'h9, 8'h5a},
		'{8'h3e, 1'b0, 9'h0ff, 4'h8, 8'hff}};

	usr_core usr_core_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(ce), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gie(i_gie),
		.i_txc_ack(i_txc_ack), .i_rxd(rxd), .i_xck(xck), .o_txd(o_txd),
		.o_txd_en(o_txd_en), .o_rxd_en(o_rxd_en), .o_irq_rx(o_irq_rx),
		.o_irq_tx(o_irq_tx), .o_irq_ue(o_irq_ue));
	usr_peer usr_peer_i (.i_mclk(i_mclk), .i_txd(o_txd), .i_txd_en(o_txd_en), .o_rxd(rxd),
		.o_xck(xck));

	function automatic logic [15:0] frm(input logic [8:0] d, input int nb,
		input logic [1:0] par);
		logic [15:0] f;
		logic        p;
		f    = '1;
		f[0] = 1'b0;
		p    = par[0];
		for (int k = 0; k < nb; k++) begin
			f[k + 1] = d[k];
			p        = p ^ d[k];
		end
		if (par[1])
			f[nb + 1] = p;
		return f;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask

	task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
		@(posedge i_mclk);
		chk({8'h00, v & m}, {8'h00, e});
	endtask

	task automatic pchk(input logic [5:0] m, input logic [5:0] e);
		#1;
		chk({10'h000, pins & m}, {10'h000, e});
		@(posedge i_mclk);
	endtask

	task automatic frchk(input logic [15:0] e);
		logic [15:0] g;
		g = 'x;
		for (int k = 0; k < 2000 && usr_peer_i.got_q.size() == 0; k++)
			@(posedge i_mclk);
		if (usr_peer_i.got_q.size() > 0)
			g = usr_peer_i.got_q.pop_front();
		chk(g, e);
	endtask

	task automatic end_sim();
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	initial begin
		#500000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		i_rst_b   = 1'b0;
		ce        = 1'b1;
		i_wr      = 1'b0;
		i_rd      = 1'b0;
		i_gie     = 1'b0;
		i_txc_ack = 1'b0;
		i_addr    = 3'h0;
		i_wdata   = 8'h00;
		repeat (12) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
		foreach (rows[r]) begin
			len = 2 + rows[r].nb + rows[r].fmt[5] + rows[r].fmt[3];
			ef  = frm(rows[r].d, rows[r].nb, rows[r].fmt[5:4]);
			usr_peer_i.rx_len = len;
			wr(ADR_FMT, rows[r].fmt);
			wr(ADR_CTB, {5'b00011, rows[r].szh, 1'b0, rows[r].d[8]});
			wr(ADR_DATA, rows[r].d[7:0]);
			frchk(ef);
			usr_peer_i.send(ef, len);
			rdchk(ADR_STA, 8'h9c, 8'h80);
			if (rows[r].nb == 4'h9)
				rdchk(ADR_CTB, 8'h02, {6'h00, rows[r].d[8], 1'b0});
			rdchk(ADR_DATA, 8'hff, rows[r].rx_holding_buffer);
		end
		// Second reset in mid-run
		i_rst_b <= 1'b0;
		repeat (12) @(posedge i_mclk);
		pchk(6'h3f, 6'h20);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
		rdchk(ADR_STA, 8'hff, 8'h20);
		rdchk(ADR_CTB, 8'hff, 8'h00);
		rdchk(ADR_FMT, 8'hff, 8'h06);
		rdchk(3'h6, 8'hff, 8'h00);
		wr(ADR_DIVH, 8'hff);
		rdchk(ADR_DIVH, 8'hff, 8'h0f);
		wr(ADR_DIVH, 8'h00);
		// Clock enable low freezes register writes
		ce <= 1'b0;
		wr(ADR_DIVL, 8'h5a);
		ce <= 1'b1;
		rdchk(ADR_DIVL, 8'hff, 8'h00);
		// Divisor and double speed
		wr(ADR_CTB, 8'h18);
		usr_peer_i.rx_len = 10;
		wr(ADR_DIVL, 8'h01);
		rdchk(ADR_DIVL, 8'hff, 8'h01);
		usr_peer_i.bit_clks = 32;
		wr(ADR_DATA, 8'h96);
		frchk(frm(9'h096, 8, 2'b00));
		repeat (32) @(posedge i_mclk);
		wr(ADR_STA, 8'h02);
		usr_peer_i.bit_clks = 16;
		wr(ADR_DATA, 8'h69);
		frchk(frm(9'h069, 8, 2'b00));
		repeat (16) @(posedge i_mclk);
		wr(ADR_STA, 8'h00);
		wr(ADR_DIVL, 8'h00);
		// Full buffer drops writes, two stop bits, done flag and requests
		wr(ADR_FMT, 8'h0e);
		wr(ADR_CTB, 8'h78);
		wr(ADR_STA, 8'h40);
		i_gie <= 1'b1;
		pchk(6'h03, 6'h01);
		usr_peer_i.rx_len = 11;
		usr_peer_i.t_q.delete();
		wr(ADR_DATA, 8'h3c);
		repeat (2) @(posedge i_mclk);
		wr(ADR_DATA, 8'hc3);
		rdchk(ADR_STA, 8'h20, 8'h00);
		pchk(6'h01, 6'h00);
		wr(ADR_DATA, 8'h55);
		frchk(frm(9'h03c, 8, 2'b00));
		frchk(frm(9'h0c3, 8, 2'b00));
		dt = usr_peer_i.t_q[1] - usr_peer_i.t_q[0];
		chk({15'h0000, dt >= 1760 && dt <= 1800}, 16'h0001);
		repeat (300) @(posedge i_mclk);
		chk(16'(usr_peer_i.got_q.size()), 16'h0000);
		pchk(6'h03, 6'h03);
		i_gie <= 1'b0;
		pchk(6'h07, 6'h00);
		i_txc_ack <= 1'b1;
		@(posedge i_mclk);
		i_txc_ack <= 1'b0;
		i_gie     <= 1'b1;
		rdchk(ADR_STA, 8'h40, 8'h00);
		// Transmitter disable waits for the frame
		wr(ADR_DATA, 8'ha7);
		wr(ADR_CTB, 8'h10);
		pchk(6'h10, 6'h10);
		frchk(frm(9'h0a7, 8, 2'b00));
		repeat (40) @(posedge i_mclk);
		pchk(6'h30, 6'h20);
		// Parity and stop bit errors
		wr(ADR_FMT, 8'h26);
		ef = frm(9'h05a, 8, 2'b10);
		usr_peer_i.send(ef ^ 16'h0200, 11);
		rdchk(ADR_STA, 8'h9c, 8'h84);
		rdchk(ADR_DATA, 8'hff, 8'h5a);
		usr_peer_i.send(ef & 16'hfbff, 12);
		rdchk(ADR_STA, 8'h9c, 8'h90);
		rdchk(ADR_DATA, 8'hff, 8'h5a);
		rdchk(ADR_STA, 8'h9c, 8'h00);
		// Overrun and fifo order
		for (int k = 1; k < 5; k++)
			usr_peer_i.send(frm(9'(k), 8, 2'b10), 11);
		rdchk(ADR_STA, 8'h88, 8'h88);
		rdchk(ADR_DATA, 8'hff, 8'h01);
		rdchk(ADR_STA, 8'h08, 8'h00);
		rdchk(ADR_DATA, 8'hff, 8'h02);
		rdchk(ADR_DATA, 8'hff, 8'h03);
		rdchk(ADR_STA, 8'h80, 8'h00);
		// Receiver disable flushes
		usr_peer_i.send(ef ^ 16'h0200, 11);
		pchk(6'h08, 6'h08);
		wr(ADR_CTB, 8'h00);
		pchk(6'h08, 6'h00);
		wr(ADR_CTB, 8'h10);
		rdchk(ADR_STA, 8'h9c, 8'h00);
		// Address filter with nine-bit frames
		wr(ADR_FMT, 8'h06);
		wr(ADR_CTB, 8'h94);
		wr(ADR_STA, 8'h01);
		usr_peer_i.send(frm(9'h033, 9, 2'b00), 11);
		rdchk(ADR_STA, 8'h80, 8'h00);
		usr_peer_i.send(frm(9'h1a5, 9, 2'b00), 11);
		pchk(6'h04, 6'h04);
		rdchk(ADR_CTB, 8'h02, 8'h02);
		rdchk(ADR_DATA, 8'hff, 8'ha5);
		pchk(6'h04, 6'h00);
		// Synchronous mode, both clock polarities
		wr(ADR_STA, 8'h00);
		wr(ADR_CTB, 8'h18);
		wr(ADR_FMT, 8'h46);
		wr(ADR_DATA, 8'hb4);
		usr_peer_i.sync_xfer(frm(9'h04b, 8, 2'b00), 11, 1'b0, ef);
		chk(ef, frm(9'h0b4, 8, 2'b00));
		rdchk(ADR_DATA, 8'hff, 8'h4b);
		wr(ADR_FMT, 8'h47);
		wr(ADR_DATA, 8'h2d);
		usr_peer_i.sync_xfer(frm(9'h0d2, 8, 2'b00), 11, 1'b1, ef);
		chk(ef, frm(9'h02d, 8, 2'b00));
		rdchk(ADR_DATA, 8'hff, 8'hd2);
		end_sim();
	end
endmodule // testbench
